//--- hdl/tfa_cfg.svh
// Purpose: Constants for the trigger, flag and terminal address block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Functional notes below
`ifndef TFA_CFG_SVH
`define TFA_CFG_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define TFA_ADDR_CFG1     8'h00
`define TFA_ADDR_CFG3     8'h04
`define TFA_ADDR_MODE     8'h08
`define TFA_ADDR_CFG5     8'h0c
`define TFA_ADDR_CFG6     8'h10
`define TFA_ADDR_STATUS   8'h14
`define TFA_ADDR_SEQCMD   8'h18
`define TFA_ADDR_INSTCNT  8'h1c

// ****************************************************************
// Field positions
// ****************************************************************
`define TFA_CFG1_SUBSYSTEM_FAULT_IN_BIT   8
`define TFA_CFG1_EXTEN_BIT    7
`define TFA_CFG3_ENH_BIT      15
`define TFA_CFG6_SRC_BIT      5
`define TFA_MODE_SEL_LSB      0
`define TFA_MODE_ALT_BIT      2
`define TFA_CMD_WAIT_BIT      0
`define TFA_CMD_STOP_BIT      1
`define TFA_ST_FLAG_BIT       0
`define TFA_ST_BCRUN_BIT      1
`define TFA_ST_WAIT_BIT       2
`define TFA_ST_MON_BIT        3
`define TFA_ST_ADDR_LSB       4
`define TFA_ST_PVALID_BIT     10

// ****************************************************************
// Reset values
// ****************************************************************
`define TFA_RST_SUBSYSTEM_FAULT_IN  1'h1
`define TFA_RST_EXTEN   1'h0
`define TFA_RST_ENH     1'h0
`define TFA_RST_SRC     1'h0
`define TFA_RST_ALT     1'h0
`define TFA_RST_ADDR    5'h00
`define TFA_RST_PAR     1'h0
`define TFA_RST_TRIG_IDLE 1'h1

// ****************************************************************
// Timing
// ****************************************************************
`define TFA_TRIG_HOLD_CLKS  4

`endif

//--- hdl/tfa_pkg.sv
// Purpose: Types for the trigger, flag and terminal address block
// Assumes: Nothing
// Notes:   Codes follow declaration order, counting up from 0
package tfa_pkg;

   typedef enum logic [1:0] {
      MODE_RT,
      MODE_BC,
      MODE_WMON,
      MODE_MMON
   } tfa_mode_t;

   typedef enum logic {
      SEQ_RUN,
      SEQ_WAIT_TRIG
   } tfa_seq_t;

endpackage

//--- hdl/tfa_edge_sync.sv
// Purpose: Two-stage synchroniser with rising edge pulse
// Assumes: Single clock domain downstream
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`include "tfa_cfg.svh"
module tfa_edge_sync (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // Line
   input  wire logic asyncIn,
   output logic      syncLevel,
   output logic      risePulse
);

   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic pulse_q;

   // Reset to the pin's idle level so release gives no false edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= `TFA_RST_TRIG_IDLE;
         sync_q <= `TFA_RST_TRIG_IDLE;
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end

   // One event per low-to-high transition of the clean level
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prev_q  <= `TFA_RST_TRIG_IDLE;
         pulse_q <= 1'h0;
      end else begin
         prev_q  <= sync_q;
         pulse_q <= sync_q & ~prev_q;
      end
   end

   assign syncLevel = sync_q;
   assign risePulse = pulse_q;

endmodule

//--- hdl/tfa_trigger_addr.sv
// Purpose: Flag/trigger pin handling and terminal address input path
// Assumes: APB slave, zero wait states, core_clk at 50 MHz
// Notes:   Trigger pin is shared between flag and trigger duties
`timescale 1ns/1ps
`include "tfa_cfg.svh"
module tfa_trigger_addr (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic        external_trigger_in,
   input  wire logic [4:0]  terminal_address_pins,
   input  wire logic        terminal_address_parity_pin,
   // Protocol side
   output logic             statusFlagBit,
   output logic             bcStartPulse,
   output logic             monStartPulse,
   output logic             seqAdvancePulse,
   output logic             seqWaiting,
   output logic [4:0]       rtAddress,
   output logic             rtParity,
   output logic             rtAddrValid
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic oddOnes(input logic [5:0] v);
      oddOnes = ^v;
   endfunction

   function automatic logic regHit(input logic [7:0] a,
                                   input logic [7:0] r);
      regHit = (a == r);
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic              ssFlagCfg_q;
   logic              extEnable_q;
   logic              enhanced_q;
   logic              addrSrc_q;
   logic              altStatus_q;
   tfa_pkg::tfa_mode_t mode_q;
   tfa_pkg::tfa_seq_t  seq_q;
   logic              bcRunning_q;
   logic              monActive_q;
   logic [15:0]       instCount_q;
   logic [4:0]        addr_q;
   logic              par_q;
   logic              addrValid_q;
   logic              flagBit_q;
   logic              bcStart_q;
   logic              monStart_q;
   logic              seqAdv_q;
   logic [31:0]       prdata_q;
   logic              pready_q;
   logic              pslverr_q;
   logic              trigLevel;
   logic              trigRise;
   logic              setupPhase;
   logic              wrDone;
   logic              mapped;
   logic [31:0]       rdData_d;
   logic              useTrig;

   // ****************************************************************
   // Trigger synchroniser
   // ****************************************************************
   tfa_edge_sync u_sync (
      .core_clk  (core_clk),
      .nrst      (nrst),
      .asyncIn   (external_trigger_in),
      .syncLevel (trigLevel),
      .risePulse (trigRise)
   );

   // Pin is ignored in message monitor and alternate status RT modes
   always_comb begin
      useTrig = 1'h1;
      if (mode_q == tfa_pkg::MODE_MMON) begin
         useTrig = 1'h0;
      end
      if ((mode_q == tfa_pkg::MODE_RT) && altStatus_q) begin
         useTrig = 1'h0;
      end
   end

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign setupPhase = psel & ~penable;
   assign wrDone     = psel & penable & pready_q & pwrite;

   always_comb begin
      mapped = regHit(paddr, `TFA_ADDR_CFG1)   |
               regHit(paddr, `TFA_ADDR_CFG3)   |
               regHit(paddr, `TFA_ADDR_MODE)   |
               regHit(paddr, `TFA_ADDR_CFG5)   |
               regHit(paddr, `TFA_ADDR_CFG6)   |
               regHit(paddr, `TFA_ADDR_STATUS) |
               regHit(paddr, `TFA_ADDR_SEQCMD) |
               regHit(paddr, `TFA_ADDR_INSTCNT);
   end

   always_comb begin
      rdData_d = 32'h0000_0000;
      unique case (paddr)
         `TFA_ADDR_CFG1: begin
            rdData_d[`TFA_CFG1_SUBSYSTEM_FAULT_IN_BIT] = ssFlagCfg_q;
            rdData_d[`TFA_CFG1_EXTEN_BIT]  = extEnable_q;
         end
         `TFA_ADDR_CFG3: begin
            rdData_d[`TFA_CFG3_ENH_BIT] = enhanced_q;
         end
         `TFA_ADDR_MODE: begin
            rdData_d[`TFA_MODE_SEL_LSB +: 2] = mode_q;
            rdData_d[`TFA_MODE_ALT_BIT]      = altStatus_q;
         end
         `TFA_ADDR_CFG5: begin
            rdData_d[5:0] = {addr_q, par_q};
         end
         `TFA_ADDR_CFG6: begin
            rdData_d[`TFA_CFG6_SRC_BIT] = addrSrc_q;
         end
         `TFA_ADDR_STATUS: begin
            rdData_d[`TFA_ST_FLAG_BIT]         = flagBit_q;
            rdData_d[`TFA_ST_BCRUN_BIT]        = bcRunning_q;
            rdData_d[`TFA_ST_WAIT_BIT]         = (seq_q ==
                                                  tfa_pkg::SEQ_WAIT_TRIG);
            rdData_d[`TFA_ST_MON_BIT]          = monActive_q;
            rdData_d[`TFA_ST_ADDR_LSB +: 6]    = {addr_q, par_q};
            rdData_d[`TFA_ST_PVALID_BIT]       = addrValid_q;
         end
         `TFA_ADDR_INSTCNT: begin
            rdData_d[15:0] = instCount_q;
         end
         default: begin
            rdData_d = 32'h0000_0000;
         end
      endcase
   end

   // Answer comes one cycle after setup: no wait states
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pready_q  <= 1'h0;
         pslverr_q <= 1'h0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setupPhase;
         pslverr_q <= setupPhase & ~mapped;
         if (setupPhase && !pwrite) begin
            prdata_q <= rdData_d;
         end else begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ssFlagCfg_q <= `TFA_RST_SUBSYSTEM_FAULT_IN;
         extEnable_q <= `TFA_RST_EXTEN;
      end else if (wrDone && regHit(paddr, `TFA_ADDR_CFG1)) begin
         ssFlagCfg_q <= pwdata[`TFA_CFG1_SUBSYSTEM_FAULT_IN_BIT];
         extEnable_q <= pwdata[`TFA_CFG1_EXTEN_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         enhanced_q <= `TFA_RST_ENH;
      end else if (wrDone && regHit(paddr, `TFA_ADDR_CFG3)) begin
         enhanced_q <= pwdata[`TFA_CFG3_ENH_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mode_q      <= tfa_pkg::MODE_RT;
         altStatus_q <= `TFA_RST_ALT;
      end else if (wrDone && regHit(paddr, `TFA_ADDR_MODE)) begin
         mode_q      <= tfa_pkg::tfa_mode_t'(
                           pwdata[`TFA_MODE_SEL_LSB +: 2]);
         altStatus_q <= pwdata[`TFA_MODE_ALT_BIT];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         addrSrc_q <= `TFA_RST_SRC;
      end else if (wrDone && regHit(paddr, `TFA_ADDR_CFG6)) begin
         addrSrc_q <= pwdata[`TFA_CFG6_SRC_BIT];
      end
   end

   // ****************************************************************
   // Terminal address
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         addr_q <= `TFA_RST_ADDR;
         par_q  <= `TFA_RST_PAR;
      end else if (!addrSrc_q) begin
         addr_q <= terminal_address_pins;
         par_q  <= terminal_address_parity_pin;
      end else if (wrDone && regHit(paddr, `TFA_ADDR_CFG5)) begin
         addr_q <= pwdata[5:1];
         par_q  <= pwdata[0];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         addrValid_q <= 1'h0;
      end else begin
         addrValid_q <= oddOnes({addr_q, par_q});
      end
   end

   // ****************************************************************
   // Subsystem flag
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         flagBit_q <= 1'h0;
      end else if ((mode_q == tfa_pkg::MODE_RT) && !altStatus_q) begin
         flagBit_q <= ~ssFlagCfg_q | ~trigLevel;
      end else begin
         flagBit_q <= ~ssFlagCfg_q;
      end
   end

   // ****************************************************************
   // Bus controller start and monitor start
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         bcStart_q   <= 1'h0;
         bcRunning_q <= 1'h0;
      end else begin
         bcStart_q <= 1'h0;
         if (trigRise && useTrig && extEnable_q && !enhanced_q &&
             (mode_q == tfa_pkg::MODE_BC)) begin
            bcStart_q   <= 1'h1;
            bcRunning_q <= 1'h1;
         end else if (wrDone && regHit(paddr, `TFA_ADDR_SEQCMD) &&
                      pwdata[`TFA_CMD_STOP_BIT]) begin
            bcRunning_q <= 1'h0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         monStart_q  <= 1'h0;
         monActive_q <= 1'h0;
      end else begin
         monStart_q <= 1'h0;
         if (trigRise && useTrig && extEnable_q &&
             (mode_q == tfa_pkg::MODE_WMON)) begin
            monStart_q  <= 1'h1;
            monActive_q <= 1'h1;
         end else if (wrDone && regHit(paddr, `TFA_ADDR_SEQCMD) &&
                      pwdata[`TFA_CMD_STOP_BIT]) begin
            monActive_q <= 1'h0;
         end
      end
   end

   // ****************************************************************
   // Enhanced sequencer wait for trigger
   // ****************************************************************
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         seq_q       <= tfa_pkg::SEQ_RUN;
         seqAdv_q    <= 1'h0;
         instCount_q <= 16'h0000;
      end else begin
         seqAdv_q <= 1'h0;
         unique case (seq_q)
            tfa_pkg::SEQ_RUN: begin
               if (wrDone && regHit(paddr, `TFA_ADDR_SEQCMD) &&
                   pwdata[`TFA_CMD_WAIT_BIT] && enhanced_q &&
                   (mode_q == tfa_pkg::MODE_BC)) begin
                  seq_q <= tfa_pkg::SEQ_WAIT_TRIG;
               end
            end
            tfa_pkg::SEQ_WAIT_TRIG: begin
               // Stalls until the edge, or until software aborts
               if (trigRise && useTrig) begin
                  seq_q       <= tfa_pkg::SEQ_RUN;
                  seqAdv_q    <= 1'h1;
                  instCount_q <= instCount_q + 16'h0001;
               end else if (!enhanced_q ||
                            (mode_q != tfa_pkg::MODE_BC) ||
                            (wrDone &&
                             regHit(paddr, `TFA_ADDR_SEQCMD) &&
                             pwdata[`TFA_CMD_STOP_BIT])) begin
                  seq_q <= tfa_pkg::SEQ_RUN;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign statusFlagBit   = flagBit_q;
   assign bcStartPulse    = bcStart_q;
   assign monStartPulse   = monStart_q;
   assign seqAdvancePulse = seqAdv_q;
   assign seqWaiting      = (seq_q == tfa_pkg::SEQ_WAIT_TRIG);
   assign rtAddress       = addr_q;
   assign rtParity        = par_q;
   assign rtAddrValid     = addrValid_q;

endmodule

//--- tb/tfa_trigger_addr_properties.sv
// Purpose: Port assertions for the trigger and address block
// Assumes: APB answers one cycle after setup
// Notes:   Bound to the design from the bench top file
`timescale 1ns/1ps
module tfa_trigger_addr_properties (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pin and protocol side
   input wire logic        external_trigger_in,
   input wire logic        bcStartPulse,
   input wire logic        monStartPulse,
   input wire logic        seqAdvancePulse,
   input wire logic        seqWaiting,
   input wire logic [4:0]  rtAddress,
   input wire logic        rtParity,
   input wire logic        rtAddrValid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_ready_after_setup:
      assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle:
      assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready:
      assert property (pslverr |-> pready)
      else $error("error without ready");
   a_idle_data_zero:
      assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_parity_valid_flag:
      assert property (rtAddrValid == ^{$past(rtAddress), $past(rtParity)})
      else $error("address valid does not match parity");
   a_bc_start_trig:
      assert property (bcStartPulse |-> $past(external_trigger_in, 2)
                       && $past(external_trigger_in, 3))
      else $error("start without trigger edge");
   a_mon_start_trig:
      assert property (monStartPulse |-> $past(external_trigger_in, 2)
                       && $past(external_trigger_in, 3))
      else $error("monitor start without trigger edge");
   a_start_single:
      assert property (bcStartPulse |=> !bcStartPulse)
      else $error("start pulse longer than one cycle");
   a_advance_from_wait:
      assert property (seqAdvancePulse |-> $past(seqWaiting)
                       && $past(external_trigger_in, 2))
      else $error("advance while not waiting");
   a_advance_ends_wait:
      assert property (seqAdvancePulse |=> !seqWaiting)
      else $error("still waiting after advance");
endmodule

//--- tb/tfa_pin_driver.sv
// Purpose: Subsystem logic driving the flag/trigger and address straps
// Assumes: Pins change just after a rising clock edge
// Notes:   Trigger idles high, so the flag is off between uses
`timescale 1ns/1ps
module tfa_pin_driver (
   // Clock
   input wire logic core_clk,
   // Pins
   output logic       external_trigger_in,
   output logic [4:0] terminal_address_pins,
   output logic       terminal_address_parity_pin
);
   initial begin
      external_trigger_in = 1'h1;
      terminal_address_pins = 5'h00;
      terminal_address_parity_pin = 1'h1;
   end

   // Low two clocks, then high four to seven clocks
   task automatic pulse();
      int hi;
      hi = 4 + ($urandom % 4);
      @(posedge core_clk) external_trigger_in <= 1'h0;
      repeat (2) @(posedge core_clk);
      external_trigger_in <= 1'h1;
      repeat (hi) @(posedge core_clk);
   endtask

   task automatic level(input logic v);
      @(posedge core_clk) external_trigger_in <= v;
   endtask

   task automatic strap(input logic [4:0] a, input logic p);
      @(posedge core_clk);
      terminal_address_pins <= a;
      terminal_address_parity_pin <= p;
   endtask
endmodule

//--- tb/tb_tfa_trigger_addr.sv
// Purpose: Self-checking bench for the trigger and address block
// Assumes: Zero wait state APB slave
// Notes:   Random straps and trigger widths from a fixed seed
`timescale 1ns/1ps
`include "tfa_cfg.svh"
module tb_tfa_trigger_addr;
   logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic        external_trigger_in, terminal_address_parity_pin, err;
   logic        statusFlagBit, bcStartPulse, monStartPulse;
   logic        seqAdvancePulse, seqWaiting, rtParity, rtAddrValid;
   logic [4:0]  terminal_address_pins, rtAddress;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          bad_count, samples_checked, nBc, nMon, nAdv;

   tfa_trigger_addr uut (.core_clk, .nrst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .external_trigger_in,
      .terminal_address_pins, .terminal_address_parity_pin, .statusFlagBit,
      .bcStartPulse, .monStartPulse, .seqAdvancePulse, .seqWaiting,
      .rtAddress, .rtParity, .rtAddrValid);
   tfa_pin_driver drv (.core_clk, .external_trigger_in,
      .terminal_address_pins, .terminal_address_parity_pin);

   always #10 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (bcStartPulse === 1'h1) nBc++;
      if (monStartPulse === 1'h1) nMon++;
      if (seqAdvancePulse === 1'h1) nAdv++;
   end

   function automatic logic odd6(input logic [5:0] v);
      return ^v;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic conclude();
      if (bad_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #100000;
      bad_count++;
      conclude();
   end

   initial begin
      logic [4:0]  a;
      logic        p;
      logic [31:0] d;
      int          k, c0, c1;
      core_clk = 1'h0;
      nrst = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      void'($urandom(32'h1f6e6b23));
      repeat (5) @(posedge core_clk);
      nrst <= 1'h1;
      apb(1'h0, `TFA_ADDR_CFG1, 32'h0);
      chk(32'(rd[8:7]), 32'h2);
      apb(1'h0, `TFA_ADDR_CFG6, 32'h0);
      chk(32'(rd[5]), 32'h0);
      apb(1'h0, 8'h20, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      // Pin straps, including all-zero and all-one corners
      for (k = 0; k < 8; k++) begin
         a = (k < 2) ? {5{k[0]}} : 5'($urandom);
         p = (k < 2) ? k[0] : 1'($urandom);
         drv.strap(a, p);
         repeat (3) @(posedge core_clk);
         chk(32'({rtAddrValid, rtParity, rtAddress}),
             32'({odd6({a, p}), p, a}));
         apb(1'h0, `TFA_ADDR_STATUS, 32'h0);
         chk(32'(rd[10:4]), 32'({odd6({a, p}), a, p}));
      end
      // Software address source ignores the pins
      apb(1'h1, `TFA_ADDR_CFG6, 32'h20);
      d = 32'($urandom % 64);
      drv.strap(~d[5:1], ~d[0]);
      apb(1'h1, `TFA_ADDR_CFG5, d);
      repeat (2) @(posedge core_clk);
      chk(32'({rtParity, rtAddress}), 32'({d[0], d[5:1]}));
      apb(1'h1, `TFA_ADDR_CFG6, 32'h0);
      // Flag level against alternate status
      for (k = 0; k < 4; k++) begin
         apb(1'h1, `TFA_ADDR_MODE, {29'h0, k[1], 2'h0});
         drv.level(k[0]);
         repeat (5) @(posedge core_clk);
         chk(32'(statusFlagBit), 32'(!k[0] && !k[1]));
         apb(1'h0, `TFA_ADDR_CFG1, 32'h0);
         chk(32'(rd[8]), 32'h1);
      end
      // Trigger in every mode, enable off and on
      for (k = 0; k < 8; k++) begin
         apb(1'h1, `TFA_ADDR_CFG1, {23'h0, 1'h1, k[0], 7'h0});
         apb(1'h1, `TFA_ADDR_MODE, 32'(k[2:1]));
         c0 = nBc;
         c1 = nMon;
         drv.pulse();
         repeat (4) @(posedge core_clk);
         chk(nBc - c0, 32'(k[2:1] == 2'h1 && k[0]));
         chk(nMon - c1, 32'(k[2:1] == 2'h2 && k[0]));
         apb(1'h0, `TFA_ADDR_STATUS, 32'h0);
         chk(32'(rd[1] | rd[3]), 32'(k[0] && k[2:1] inside {1, 2}));
         apb(1'h1, `TFA_ADDR_SEQCMD, 32'h2);
      end
      // Enhanced sequencer waits for each edge
      apb(1'h1, `TFA_ADDR_CFG3, 32'h8000);
      apb(1'h1, `TFA_ADDR_MODE, 32'h1);
      for (k = 0; k < 3; k++) begin
         apb(1'h1, `TFA_ADDR_SEQCMD, 32'h1);
         repeat (10 + k) @(posedge core_clk);
         chk(32'(seqWaiting), 32'h1);
         c0 = nAdv;
         c1 = nBc;
         drv.pulse();
         repeat (4) @(posedge core_clk);
         chk(32'(seqWaiting), 32'h0);
         chk(nAdv - c0, 32'h1);
         chk(nBc - c1, 32'h0);
      end
      apb(1'h0, `TFA_ADDR_INSTCNT, 32'h0);
      chk(32'(rd[15:0]), 32'h3);
      conclude();
   end
endmodule

bind tfa_trigger_addr tfa_trigger_addr_properties chk_i (.core_clk, .nrst,
   .psel, .penable, .prdata, .pready, .pslverr, .external_trigger_in,
   .bcStartPulse, .monStartPulse, .seqAdvancePulse, .seqWaiting,
   .rtAddress, .rtParity, .rtAddrValid);
